// ---- rtl/ext_osc_pkg.sv ----
package ext_osc_pkg;
	// register indices; each register takes one aligned word at four times its index
	localparam logic [7:0] CTRL_INDEX = 8'hb5;
	localparam logic [7:0] IRQ_STATUS_INDEX = 8'hb6;
	localparam logic [7:0] IRQ_MASK_INDEX = 8'hb7;
	localparam int ADDR_W = 12;
	localparam logic [ADDR_W-1:0] CTRL_ADDR = {2'h0, CTRL_INDEX, 2'h0};
	localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR = {2'h0, IRQ_STATUS_INDEX, 2'h0};
	localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = {2'h0, IRQ_MASK_INDEX, 2'h0};
	localparam int DATA_W = 32;

	// oscillator mode codes
	localparam logic [2:0] MODE_OFF0 = 3'h0;
	localparam logic [2:0] MODE_OFF1 = 3'h1;
	localparam logic [2:0] MODE_CMOS = 3'h2;
	localparam logic [2:0] MODE_CMOS_DIV2 = 3'h3;
	localparam logic [2:0] MODE_RC = 3'h4;
	localparam logic [2:0] MODE_CAP = 3'h5;
	localparam logic [2:0] MODE_XTAL = 3'h6;
	localparam logic [2:0] MODE_XTAL_DIV2 = 3'h7;

	// control byte layout: valid flag, mode, unused bit, frequency control
	typedef struct packed {
		logic crystalValidFlag;
		logic [2:0] extOscModeSel;
		logic unusedBit;
		logic [2:0] extOscFreqCtrl;
	} osc_ctrl_t;
	localparam osc_ctrl_t CTRL_RESET = 8'h00;
	localparam logic [2:0] FREQ_LOWEST = 3'h0;

	// interrupt status and mask layout
	typedef struct packed {
		logic lostValid;
		logic gainedValid;
	} osc_irq_t;
	localparam osc_irq_t IRQ_RESET = 2'h0;
	localparam int IRQ_W = 2;

	// decoded mode outputs travelling together
	typedef struct packed {
		logic oscEnable;
		logic modeCmos;
		logic modeRc;
		logic modeCap;
		logic modeXtal;
		logic divideByTwo;
		logic pinInUsed;
		logic pinOutUsed;
	} osc_mode_t;

	// crystal stability tracking states
	typedef enum logic [2:0] {
		XS_IDLE = 3'b001,
		XS_WAIT = 3'b010,
		XS_VALID = 3'b100
	} xtal_state_t;
endpackage : ext_osc_pkg

// ---- rtl/ext_osc_control.sv ----
// Functional notes
// (RULE1) Control byte lives at index 0xb5 and holds mode, frequency and status fields.
// (RULE2) Bit 7 is a read-only valid flag: one only while the crystal runs stably.
// (RULE3) The valid flag means something only in crystal modes 11x.
// (RULE4) Mode field bits 6:4 at 00x switch the external oscillator off.
// (RULE5) Mode 010 passes a CMOS clock; 011 adds a divide-by-two stage.
// (RULE6) Mode 100 selects RC operation; 101 selects capacitor operation.
// (RULE7) Mode 110 selects crystal operation; 111 adds a divide-by-two stage.
// (RULE8) Bit 3 is unimplemented: reads zero, writes ignored.
// (RULE9) In crystal mode software sets frequency code by band, 32 kHz up to 30 MHz.
// (RULE10) In RC mode software sets frequency code by band, 25 kHz doubling upward.
// (RULE11) In capacitor mode the code picks the gain factor, 0.87 up to 1590.
// (RULE12) Software waits at least 1 ms after enabling crystal before sampling valid.
// (RULE13) Software drives pins low, makes them analog, enables, polls valid, then switches.
// (RULE14) After a watch crystal settles software may drop frequency code to 000.
// (RULE15) Software should enable the missing-clock detector before switching clocks.
// (RULE16) Crystal mode uses both oscillator pins; other modes use only the output pin. Off modes 00x here use neither pin.
// (RULE17) Reset clears every field: oscillator off, lowest frequency code, valid zero.
// (RULE18) Writes to the valid flag position have no effect.
module ext_osc_control
	import ext_osc_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	input wire logic [DATA_W/8-1:0] pstrb,
	output logic pready,
	output logic [DATA_W-1:0] prdata,
	output logic pslverr,
	// amplitude detector indication, asynchronous
	input wire logic ampStable,
	// oscillator drive controls
	output osc_mode_t oscMode,
	output logic [2:0] extOscFreqCtrl,
	// interrupt
	output logic irq
);

	osc_ctrl_t ctrl_q, ctrl_d;
	osc_irq_t status_q, status_d, mask_q, mask_d;
	xtal_state_t state_q, state_d;
	osc_mode_t mode_q, mode_d;
	logic [DATA_W-1:0] rdata_q, rdata_d;
	logic err_q;
	logic sync1_q, sync2_q, sync3_q, ampOk_q;

	// mode classes, shared by the decode and by the checks below
	function automatic logic xtalCode(input logic [2:0] m);
		return (m == MODE_XTAL) || (m == MODE_XTAL_DIV2);
	endfunction : xtalCode

	function automatic logic offCode(input logic [2:0] m);
		return (m == MODE_OFF0) || (m == MODE_OFF1);
	endfunction : offCode

	// bus data seen through the register layouts, so no field position is spelled out
	osc_ctrl_t wrView, rdView;
	osc_irq_t wrBits;
	assign wrView = pwdata[$bits(osc_ctrl_t)-1:0];
	assign rdView = prdata[$bits(osc_ctrl_t)-1:0];
	assign wrBits = pwdata[IRQ_W-1:0];

	// bus decode
	wire setupPhase = psel && !penable;
	wire accessPhase = psel && penable;
	wire wrAccess = accessPhase && pwrite && pstrb[0];
	wire hitCtrl = (paddr == CTRL_ADDR);
	wire hitStatus = (paddr == IRQ_STATUS_ADDR);
	wire hitMask = (paddr == IRQ_MASK_ADDR);
	wire hitAny = hitCtrl || hitStatus || hitMask;
	wire wrCtrl = wrAccess && hitCtrl;
	wire wrStatus = wrAccess && hitStatus;
	wire wrMask = wrAccess && hitMask;

	// mode decode from the stored field
	wire [2:0] modeSel = ctrl_q.extOscModeSel;
	wire xtalSel = xtalCode(modeSel); // RULE3
	wire offSel = offCode(modeSel); // RULE4

	// the valid flag is derived, never stored from the bus
	wire validFlag = (state_q == XS_VALID); // RULE2 RULE18
	wire gainEvt = (state_d == XS_VALID) && (state_q != XS_VALID);
	wire loseEvt = (state_q == XS_VALID) && (state_d == XS_WAIT);
	osc_irq_t events;
	assign events = '{lostValid: loseEvt, gainedValid: gainEvt};

	// read view of the control byte: bit 3 forced low, bit 7 from the tracker
	osc_ctrl_t ctrlView;
	assign ctrlView = '{crystalValidFlag: validFlag, extOscModeSel: ctrl_q.extOscModeSel,
		unusedBit: 1'b0, extOscFreqCtrl: ctrl_q.extOscFreqCtrl}; // RULE8

	// next control value; only mode and frequency bits are writable
	always_comb begin
		ctrl_d = ctrl_q;
		if (wrCtrl) begin
			ctrl_d.extOscModeSel = wrView.extOscModeSel; // RULE1 RULE4
			ctrl_d.extOscFreqCtrl = wrView.extOscFreqCtrl; // RULE9 RULE10 RULE11 RULE14
		end
		ctrl_d.crystalValidFlag = 1'b0; // RULE18
		ctrl_d.unusedBit = 1'b0; // RULE8
	end

	// sticky status: a set in the clearing cycle survives
	assign status_d = (wrStatus ? (status_q & ~wrBits) : status_q) | events;
	assign mask_d = wrMask ? wrBits : mask_q;

	// read mux, sampled in the setup cycle so the data come from flops
	always_comb begin
		rdata_d = '0;
		if (hitCtrl) begin
			rdata_d[$bits(osc_ctrl_t)-1:0] = ctrlView;
		end else if (hitStatus) begin
			rdata_d[IRQ_W-1:0] = status_q;
		end else if (hitMask) begin
			rdata_d[IRQ_W-1:0] = mask_q;
		end
	end

	// crystal stability tracking; leaving crystal mode always returns to idle
	always_comb begin
		state_d = state_q;
		case (state_q)
			XS_IDLE: begin
				if (xtalSel) state_d = XS_WAIT;
			end
			XS_WAIT: begin
				if (!xtalSel) state_d = XS_IDLE;
				else if (ampOk_q) state_d = XS_VALID; // RULE2
			end
			XS_VALID: begin
				if (!xtalSel) state_d = XS_IDLE; // RULE3
				else if (!ampOk_q) state_d = XS_WAIT;
			end
			default: state_d = XS_IDLE;
		endcase
	end

	// drive decode, registered so outputs are glitch free toward the analog cell
	always_comb begin
		mode_d.oscEnable = !offSel; // RULE4
		mode_d.modeCmos = (modeSel == MODE_CMOS) || (modeSel == MODE_CMOS_DIV2); // RULE5
		mode_d.modeRc = (modeSel == MODE_RC); // RULE6
		mode_d.modeCap = (modeSel == MODE_CAP); // RULE6
		mode_d.modeXtal = xtalSel; // RULE7
		mode_d.divideByTwo = (modeSel == MODE_CMOS_DIV2) || (modeSel == MODE_XTAL_DIV2); // RULE5 RULE7
		mode_d.pinInUsed = xtalSel; // RULE16
		mode_d.pinOutUsed = !offSel; // RULE16
	end

	// detector synchroniser: a change counts once stages two and three agree
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			sync3_q <= 1'b0;
			ampOk_q <= 1'b0;
		end else begin
			sync1_q <= ampStable;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			if (sync2_q == sync3_q) ampOk_q <= sync3_q;
		end
	end

	// register state
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ctrl_q <= CTRL_RESET; // RULE17
			status_q <= IRQ_RESET;
			mask_q <= IRQ_RESET;
			state_q <= XS_IDLE;
			mode_q <= '0;
		end else begin
			ctrl_q <= ctrl_d;
			status_q <= status_d;
			mask_q <= mask_d;
			state_q <= state_d;
			mode_q <= mode_d;
		end
	end

	// bus answer flops
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rdata_q <= '0;
			err_q <= 1'b0;
		end else if (setupPhase) begin
			rdata_q <= rdata_d;
			err_q <= !hitAny;
		end
	end

	// zero wait states: every access completes in its first access cycle
	assign pready = 1'b1;
	assign prdata = rdata_q;
	assign pslverr = accessPhase && err_q;
	assign oscMode = mode_q;
	assign extOscFreqCtrl = ctrl_q.extOscFreqCtrl; // RULE9 RULE10 RULE11 RULE14
	assign irq = |(status_q & mask_q);

	// bus checks: stores, strobe gating and error answers
	ctrl_write_a: assert property (@(posedge core_clk) disable iff (rst) // RULE1
		wrCtrl |=> (ctrl_q.extOscModeSel == $past(wrView.extOscModeSel))
			&& (extOscFreqCtrl == $past(wrView.extOscFreqCtrl)))
		else $error("control write not stored");
	strobe_gate_a: assert property (@(posedge core_clk) disable iff (rst) // RULE1
		accessPhase && pwrite && !pstrb[0] |=> $stable(ctrl_q) && $stable(mask_q))
		else $error("write without strobe took effect");
	unmapped_err_a: assert property (@(posedge core_clk) disable iff (rst) // RULE1
		accessPhase && !hitAny |-> pslverr)
		else $error("unmapped access not refused");
	mapped_ok_a: assert property (@(posedge core_clk) disable iff (rst) // RULE1
		accessPhase && hitAny |-> !pslverr)
		else $error("mapped access refused");
	mask_write_a: assert property (@(posedge core_clk) disable iff (rst)
		wrMask |=> mask_q == $past(wrBits))
		else $error("mask write not stored");

	// valid flag tracking; the flag drops one cycle after crystal mode is left and rises one cycle after the detector settles
	valid_latency_a: assert property (@(posedge core_clk) disable iff (rst) // RULE2
		(state_q == XS_WAIT) && xtalSel && ampOk_q |=> validFlag)
		else $error("valid flag did not rise");
	flag_read_a: assert property (@(posedge core_clk) disable iff (rst) // RULE2 RULE8
		setupPhase && hitCtrl |=> rdView == $past(ctrlView))
		else $error("control read view wrong");
	valid_mode_a: assert property (@(posedge core_clk) disable iff (rst) // RULE3
		validFlag |-> $past(xtalSel) && $past(ampOk_q))
		else $error("valid flag outside crystal mode");
	valid_drop_a: assert property (@(posedge core_clk) disable iff (rst) // RULE3
		!xtalSel |=> !validFlag)
		else $error("valid flag kept after leaving crystal mode");
	off_mode_a: assert property (@(posedge core_clk) disable iff (rst) // RULE4
		offSel |=> !oscMode.oscEnable && !oscMode.pinOutUsed)
		else $error("oscillator enabled in off mode");
	cmos_mode_a: assert property (@(posedge core_clk) disable iff (rst) // RULE5
		(modeSel == MODE_CMOS) |=> oscMode.modeCmos && !oscMode.divideByTwo)
		else $error("cmos mode decode wrong");
	cmos_div_a: assert property (@(posedge core_clk) disable iff (rst) // RULE5
		(modeSel == MODE_CMOS_DIV2) |=> oscMode.modeCmos && oscMode.divideByTwo
			&& !oscMode.pinInUsed)
		else $error("cmos divide mode decode wrong");
	rc_cap_a: assert property (@(posedge core_clk) disable iff (rst) // RULE6
		(modeSel == MODE_CAP) |=> oscMode.modeCap && !oscMode.modeRc && !oscMode.pinInUsed)
		else $error("capacitor mode decode wrong");
	rc_mode_a: assert property (@(posedge core_clk) disable iff (rst) // RULE6
		(modeSel == MODE_RC) |=> oscMode.modeRc && !oscMode.modeCap && oscMode.oscEnable)
		else $error("rc mode decode wrong");
	xtal_div_a: assert property (@(posedge core_clk) disable iff (rst) // RULE7
		(modeSel == MODE_XTAL_DIV2) |=> oscMode.modeXtal && oscMode.divideByTwo)
		else $error("crystal divide mode decode wrong");
	xtal_mode_a: assert property (@(posedge core_clk) disable iff (rst) // RULE7
		(modeSel == MODE_XTAL) |=> oscMode.modeXtal && !oscMode.divideByTwo
			&& oscMode.pinInUsed)
		else $error("crystal mode decode wrong");
	unused_bit_a: assert property (@(posedge core_clk) disable iff (rst) // RULE8
		setupPhase && !pwrite && hitCtrl |=> !rdView.unusedBit)
		else $error("unused bit read as one");
	// reset is sampled one edge later, once the asynchronous clear has settled
	reset_clear_a: assert property (@(posedge core_clk) // RULE17
		rst |=> (ctrl_q == CTRL_RESET) && !validFlag && !irq)
		else $error("control not cleared by reset");
	valid_write_a: assert property (@(posedge core_clk) disable iff (rst) // RULE18
		wrCtrl && wrView.crystalValidFlag && !xtalCode(wrView.extOscModeSel)
			|=> ##1 !validFlag)
		else $error("valid flag written by software");

	// interrupt status: events are sticky and a clear never hides a fresh one
	sticky_set_a: assert property (@(posedge core_clk) disable iff (rst)
		(gainEvt || loseEvt) |=> (status_q & $past(events)) == $past(events))
		else $error("event lost on clear");
	gain_status_a: assert property (@(posedge core_clk) disable iff (rst)
		$rose(validFlag) |-> status_q.gainedValid)
		else $error("gain event not recorded");
	lose_status_a: assert property (@(posedge core_clk) disable iff (rst)
		$fell(validFlag) && $past(xtalSel) |-> status_q.lostValid)
		else $error("loss event not recorded");
	status_clear_a: assert property (@(posedge core_clk) disable iff (rst)
		wrStatus && wrBits.gainedValid && !gainEvt |=> !status_q.gainedValid)
		else $error("status bit not cleared");

	// the detector level only moves once the last two stages agree
	sync_agree_a: assert property (@(posedge core_clk) disable iff (rst)
		sync2_q != sync3_q |=> $stable(ampOk_q))
		else $error("detector level moved while unsettled");

	// main scenarios
	xtal_valid_c: cover property (@(posedge core_clk) disable iff (rst) $rose(validFlag));
	valid_lost_c: cover property (@(posedge core_clk) disable iff (rst) loseEvt);
	irq_raise_c: cover property (@(posedge core_clk) disable iff (rst) $rose(irq));
	bad_addr_c: cover property (@(posedge core_clk) disable iff (rst) pslverr);
	div_mode_c: cover property (@(posedge core_clk) disable iff (rst)
		oscMode.modeXtal && oscMode.divideByTwo);

endmodule : ext_osc_control

// ---- testbench/ext_osc_partner.sv ----
module ext_osc_partner
	import ext_osc_pkg::*;
#(
	parameter int SETTLE = 40
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// drive from the block, fault knob from the bench
	input wire osc_mode_t oscMode,
	input wire logic ampDrop,
	// amplitude indication
	output logic ampStable
);
	timeunit 1ns;
	timeprecision 1ps;
	int settleCnt;
	logic xtalWired;
	// a crystal needs both pins driven; other modes leave it dead
	assign xtalWired = oscMode.modeXtal & oscMode.pinInUsed & oscMode.pinOutUsed;
	// amplitude builds slowly, so a quick poll must still see no valid flag
	always @(posedge core_clk or posedge rst) begin
		if (rst || !xtalWired || ampDrop) begin
			settleCnt <= 0;
		end else if (settleCnt < SETTLE) begin
			settleCnt <= settleCnt + 1;
		end
	end
	assign ampStable = (settleCnt >= SETTLE);
endmodule : ext_osc_partner

// ---- testbench/external_oscillator_control_tb_top.sv ----
`define CHK(nm, ex, got) begin checkCount++; if ((got) !== (ex)) begin failCount++; \
	$display("ERROR %s expected %h seen %h", nm, ex, got); end end
module external_oscillator_control_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import ext_osc_pkg::*;
	typedef struct packed {logic [7:0] wr; logic [7:0] rd;} row_t;
	logic core_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [DATA_W-1:0] pwdata = '0, prdata, rv;
	logic [3:0] pstrb = 4'hf;
	logic pready, pslverr, ampStable, ampDrop = 1'b0, irq, ev;
	osc_mode_t oscMode;
	logic [2:0] extOscFreqCtrl;
	int failCount = 0, checkCount = 0, cycles = 0;
	// bits 7 and 3 set on every write: both must read back zero
	row_t rows[8] = '{'{8'h8f, 8'h07}, '{8'h9e, 8'h16}, '{8'had, 8'h25}, '{8'hbc, 8'h34},
		'{8'hcb, 8'h43}, '{8'hda, 8'h52}, '{8'he9, 8'h61}, '{8'hf8, 8'h70}};
	ext_osc_control uut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .ampStable(ampStable), .oscMode(oscMode),
		.extOscFreqCtrl(extOscFreqCtrl), .irq(irq));
	ext_osc_partner partner (.core_clk(core_clk), .rst(rst), .oscMode(oscMode),
		.ampDrop(ampDrop), .ampStable(ampStable));
	initial begin
		forever #5 core_clk = ~core_clk;
	end
	// hang guard, generous against the few hundred cycles the run needs
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 5000) begin
			failCount++;
			testDone();
		end
	end
	task automatic testDone();
		$display("checks %0d mismatches %0d", checkCount, failCount);
		if (failCount == 0 && checkCount > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : testDone
	// one apb transfer; idles one cycle after so strobes never change twice per step
	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1);
		rv = prdata;
		ev = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask : apb
	// bounded poll until all bits of m read set
	task automatic poll(input logic [ADDR_W-1:0] a, input logic [31:0] m);
		int n;
		n = 0;
		do begin
			apb(1'b0, a, 32'h0);
			n++;
		end while ((rv & m) !== m && n < 40);
	endtask : poll
	function automatic osc_mode_t expMode(input logic [2:0] m);
		osc_mode_t x;
		x = '{m[2] | m[1], m[2:1] == 2'h1, m == 3'h4, m == 3'h5, m[2] & m[1],
			m[1] & m[0], m[2] & m[1], m[2] | m[1]};
		return x;
	endfunction : expMode
	initial begin
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		`CHK("reset mode", 8'h00, oscMode)
		`CHK("reset freq", 3'h0, extOscFreqCtrl)
		apb(1'b0, CTRL_ADDR, 32'h0);
		`CHK("reset ctrl", 32'h0, rv)
		for (int i = 0; i < 8; i++) begin
			apb(1'b1, CTRL_ADDR, {24'h0, rows[i].wr});
			apb(1'b0, CTRL_ADDR, 32'h0);
			`CHK("ctrl read", {24'h0, rows[i].rd}, rv)
			`CHK("mode out", expMode(rows[i].rd[6:4]), oscMode)
			`CHK("freq out", rows[i].rd[2:0], extOscFreqCtrl)
		end
		// unmapped place: error, zero data, no side effect
		apb(1'b1, 12'h2e0, 32'h20);
		apb(1'b0, 12'h2e0, 32'h0);
		`CHK("unmapped err", 1'b1, ev)
		`CHK("unmapped data", 32'h0, rv)
		apb(1'b0, CTRL_ADDR, 32'h0);
		`CHK("ctrl kept", 32'h70, rv)
		`CHK("ctrl err", 1'b0, ev)
		// crystal start: gain raises flag and unmasked irq
		// the missing-clock detector sits outside; the bench never moves the system clock
		apb(1'b1, IRQ_MASK_ADDR, 32'h3);
		apb(1'b1, CTRL_ADDR, 32'h67);
		apb(1'b0, CTRL_ADDR, 32'h0);
		`CHK("flag early", 1'b0, rv[7])
		poll(CTRL_ADDR, 32'h80);
		`CHK("flag valid", 32'he7, rv)
		`CHK("gain irq", 1'b1, irq)
		apb(1'b1, CTRL_ADDR, 32'h60);
		apb(1'b0, CTRL_ADDR, 32'h0);
		`CHK("flag write", 32'he0, rv)
		apb(1'b1, IRQ_STATUS_ADDR, 32'h1);
		`CHK("clear irq", 1'b0, irq)
		// loss of amplitude while masked, then unmasked
		apb(1'b1, IRQ_MASK_ADDR, 32'h0);
		ampDrop <= 1'b1;
		poll(IRQ_STATUS_ADDR, 32'h2);
		`CHK("lost status", 32'h2, rv)
		`CHK("masked irq", 1'b0, irq)
		apb(1'b1, IRQ_MASK_ADDR, 32'h2);
		`CHK("lost irq", 1'b1, irq)
		apb(1'b1, IRQ_STATUS_ADDR, 32'h2);
		`CHK("lost clear", 1'b0, irq)
		ampDrop <= 1'b0;
		poll(CTRL_ADDR, 32'h80);
		apb(1'b1, CTRL_ADDR, 32'h20);
		apb(1'b0, CTRL_ADDR, 32'h0);
		`CHK("flag cmos", 32'h20, rv)
		// a write with the low byte strobe off must leave the register alone
		pstrb <= 4'h0;
		apb(1'b1, CTRL_ADDR, 32'h45);
		pstrb <= 4'hf;
		apb(1'b0, CTRL_ADDR, 32'h0);
		`CHK("strobe off", 32'h20, rv)
		testDone();
	end
endmodule : external_oscillator_control_tb_top
